// *** src/sfce_pkg.sv ***
// constants, types and carriers of the forward command engine.
// assumes one core clock; the host port and the link are plain pins.
// Function
// - unchecked variants execute despite bad crc
// - checked variants execute only on crc match
// - frame: start bit, word+check bit, end byte
// - ack: status word then its crc
// - ack suppressed while ack disable set
// - register reads and writes, receive queue reads
// - checked forward waits for crc, ignores threshold
// - checked forward takes up to 512 words
// - unchecked forward takes up to 4096 words
// - tail forwards take at most 31 words
// - unchecked starts at threshold or all received
// - unchecked crc mismatch sets flag, drives fault
// - tail forwards append requested extra end bytes
// - data and extra end bytes: one unbroken transfer
// - zero words: only extra end bytes sent
// - plain length is count-1, optional is count
// - up to 127 extra end bytes, 7 bits
// - crc ccitt-false default, xmodem by configuration
package sfce_pkg;

  localparam int unsigned WORD_W         = 16;
  localparam int unsigned THR_W          = 10;
  localparam int unsigned CORE_PERIOD_NS = 20;
  localparam int unsigned LINK_PERIOD_NS = 160;
  localparam int unsigned LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CORE_PERIOD_NS);
  localparam int unsigned DIV_W          = 3;

  localparam logic [3:0]  OP_CHECKED_FORWARD_WRITE_CMD        = 4'h2;
  localparam logic [3:0]  OP_UNCHECKED_FORWARD_WRITE_CMD      = 4'h3;
  localparam logic [3:0]  OP_CHECKED_FORWARD_WRITE_TAIL_CMD   = 4'h4;
  localparam logic [3:0]  OP_UNCHECKED_FORWARD_WRITE_TAIL_CMD = 4'h5;
  localparam logic [3:0]  OP_CHECKED_REG_WRITE_CMD            = 4'ha;
  localparam logic [3:0]  OP_UNCHECKED_REG_WRITE_CMD          = 4'hb;
  localparam logic [3:0]  OP_CHECKED_SOFT_RESET_CMD           = 4'he;
  localparam logic [11:0] SOFT_RESET_KEY                      = 12'h1e1;

  localparam logic [15:0] CRC_POLY        = 16'h1021;
  localparam logic [15:0] CRC_INIT_CCITT  = 16'hffff;
  localparam logic [15:0] CRC_INIT_XMODEM = 16'h0000;
  localparam logic [7:0]  END_BYTE        = 8'hff;
  localparam logic [2:0]  PIN_IDLE_HIGH   = 3'h7;

  typedef enum logic [4:0] {
    P_CMD  = 5'b00001,
    P_DATA = 5'b00010,
    P_CRC  = 5'b00100,
    P_RET  = 5'b01000,
    P_DONE = 5'b10000
  } sfce_phase_e;

  typedef enum logic [4:0] {
    L_IDLE  = 5'b00001,
    L_START = 5'b00010,
    L_DATA  = 5'b00100,
    L_END   = 5'b01000,
    L_XEND  = 5'b10000
  } sfce_link_e;

  typedef struct packed {
    logic             ack_disable_bit;
    logic             crc_xmodem;
    logic             fault_mask;
    logic [THR_W-1:0] transmit_start_threshold;
  } sfce_cfg_s;

  typedef struct packed {
    logic              stb;
    logic              shadow;
    logic [3:0]        addr;
    logic [WORD_W-1:0] data;
  } sfce_regwr_s;

  function automatic logic [15:0] sfce_crc_bit(input logic [15:0] c, input logic b);
    return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
  endfunction

endpackage

// *** src/sfce_engine.sv ***
// host command port, transmit queue and downstream serializer.
// assumes spi mode 0 pins sampled by the core clock at 8x or more.
`timescale 1ns/1ps
`default_nettype none

module sfce_engine
  import sfce_pkg::*;
#(
  parameter int unsigned TXQ_DEPTH = 512
) (
  input  wire logic              core_clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              spi_sclk_in,
  input  wire logic              spi_cs_n_in,
  input  wire logic              spi_sdi_in,
  output logic                   spi_sdo_out,
  input  wire sfce_cfg_s         cfg_in,
  input  wire logic [WORD_W-1:0] status_word_in,
  input  wire logic [WORD_W-1:0] rd_word_in,
  output logic                   rd_sel_out,
  output logic [3:0]             rd_addr_out,
  output logic                   rd_pop_out,
  output sfce_regwr_s            regwr_out,
  output logic                   reg_commit_out,
  output logic                   soft_reset_out,
  input  wire logic              crc_err_clear_in,
  output logic                   crc_err_flag_out,
  output logic                   fault_od_out,
  output logic                   fault_oe_n_out,
  output logic                   link_clk_out,
  output logic                   link_dat_out,
  output logic                   link_busy_out
);

  localparam int unsigned AW = $clog2(TXQ_DEPTH);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LINK_HALF_CYC - 1);

  typedef struct packed {
    logic [2:0]        sclk_m;
    logic [2:0]        cs_m;
    logic [2:0]        sdi_m;
    logic              sclk_lvl;
    logic              cs_lvl;
    sfce_phase_e       ph;
    logic [3:0]        bitc;
    logic [15:0]       rx_sh;
    logic [15:0]       cmd;
    logic [15:0]       crc_rx;
    logic [15:0]       crc_tx;
    logic [15:0]       tx_sh;
    logic              xmodem;
    logic [12:0]       data_left;
    logic [8:0]        ret_len;
    logic [8:0]        ret_left;
    logic              ret_crc;
    logic              sdo;
    logic [3:0]        rd_addr;
    logic              rd_sel;
    logic              rd_pop;
    sfce_regwr_s       regwr;
    logic              commit;
    logic              soft_rst;
    logic              crc_err;
    logic              fault;
    logic [AW-1:0]     q_wr;
    logic [AW-1:0]     q_rd;
    logic [AW-1:0]     q_mark;
    logic [AW:0]       q_cnt;
    logic              job_valid;
    logic              job_chk;
    logic              released;
    logic              all_rx;
    logic [12:0]       job_words;
    logic [6:0]        job_xb;
    sfce_link_e        lst;
    logic [DIV_W-1:0]  div;
    logic              lclk;
    logic              ldat;
    logic [15:0]       lsh;
    logic [3:0]        lbits;
  } sfce_st_s;

  localparam sfce_st_s ST_RST = '{cs_m: PIN_IDLE_HIGH, sdi_m: PIN_IDLE_HIGH, cs_lvl: 1'b1, sdo: 1'b1,
                                  crc_rx: CRC_INIT_CCITT, ph: P_CMD, lst: L_IDLE, default: '0};

  sfce_st_s          s;
  sfce_st_s          n;
  logic [15:0]       mem [TXQ_DEPTH];
  logic [15:0]       qword;
  logic [15:0]       word;
  logic [15:0]       ret_w;
  logic [15:0]       crc_nx;
  logic [12:0]       dlen;
  logic [8:0]        rl;
  logic [6:0]        xb_left;
  logic [AW:0]       q_base;
  logic [3:0]        op;
  logic              chk;
  logic              ok;
  logic              fwd_op;
  logic              rwr_op;
  logic              rd_op;
  logic              ack_op;
  logic              rise;
  logic              fall;
  logic              push;
  logic              pop;
  logic              flush;
  logic              bit_tick;
  logic              cut;

  assign qword = mem[s.q_rd];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n        = s;
    word     = {s.rx_sh[14:0], s.sdi_m[2]};
    op       = s.cmd[15:12];
    chk      = ~op[0];
    ok       = (word == s.crc_rx);
    fwd_op   = op inside {[OP_CHECKED_FORWARD_WRITE_CMD : OP_UNCHECKED_FORWARD_WRITE_TAIL_CMD]};
    rwr_op   = op inside {OP_CHECKED_REG_WRITE_CMD, OP_UNCHECKED_REG_WRITE_CMD};
    rd_op    = op inside {4'h8, 4'h9, 4'hc, 4'hd};
    ack_op   = fwd_op | rwr_op | (op == OP_CHECKED_SOFT_RESET_CMD);
    crc_nx   = sfce_crc_bit(s.crc_tx, s.tx_sh[15]);
    ret_w    = 16'h0000;
    rl       = 9'h000;
    dlen     = 13'h0000;
    xb_left  = s.job_xb;
    push     = 1'b0;
    pop      = 1'b0;
    flush    = 1'b0;
    rise     = 1'b0;
    fall     = 1'b0;
    cut      = 1'b0;
    n.regwr.stb = 1'b0;
    n.rd_pop    = 1'b0;
    n.commit    = 1'b0;
    n.soft_rst  = 1'b0;
    // first stage feeds only the second; a level counts once stages 2 and 3 agree
    n.sclk_m = {s.sclk_m[1:0], spi_sclk_in};
    n.cs_m   = {s.cs_m[1:0], spi_cs_n_in};
    n.sdi_m  = {s.sdi_m[1:0], spi_sdi_in};
    if (s.sclk_m[2] == s.sclk_m[1] && s.sclk_m[2] != s.sclk_lvl) begin
      n.sclk_lvl = s.sclk_m[2];
      rise       = s.sclk_m[2];
      fall       = ~s.sclk_m[2];
    end
    if (s.cs_m[2] == s.cs_m[1]) begin
      n.cs_lvl = s.cs_m[2];
    end
    if (crc_err_clear_in) begin
      n.crc_err = 1'b0;
    end
    // unchecked job: whichever of threshold or last word comes first
    if (s.job_valid && !s.job_chk && !s.released &&
        (s.all_rx || s.q_cnt >= (AW+1)'(cfg_in.transmit_start_threshold))) begin
      n.released = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    if (s.cs_lvl) begin
      n.ph     = P_CMD;
      n.bitc   = 4'h0;
      n.xmodem = cfg_in.crc_xmodem;
      n.crc_rx = cfg_in.crc_xmodem ? CRC_INIT_XMODEM : CRC_INIT_CCITT;
      // select dropped before the crc word: without this the job would wait forever
      cut = (s.ph == P_DATA || s.ph == P_CRC) && fwd_op && s.job_valid;
      if (cut && s.job_chk) begin
        flush       = 1'b1;
        n.job_valid = 1'b0;
        n.q_wr      = s.q_mark;
      end else if (cut) begin
        n.all_rx = 1'b1;
      end
    end else if (rise) begin
      n.rx_sh = word;
      n.bitc  = s.bitc + 4'h1;
      if (s.ph == P_CMD || s.ph == P_DATA) begin
        n.crc_rx = sfce_crc_bit(s.crc_rx, s.sdi_m[2]);
      end
      if (s.ph == P_RET) begin
        n.crc_tx = crc_nx;
      end
      if (s.bitc == 4'hf) begin
        unique case (s.ph)
          P_CMD: begin
            n.cmd     = word;
            n.rd_addr = word[9:6];
            n.rd_sel  = (word[15:13] == 3'b100);
            n.ret_len = (word[15:13] == 3'b100) ? {1'b0, word[7:0]} + 9'h001 : {5'h00, word[3:0]} + 9'h001;
            unique case (word[15:12])
              OP_CHECKED_FORWARD_WRITE_CMD:   dlen = {4'h0, word[8:0]} + 13'h0001;
              OP_UNCHECKED_FORWARD_WRITE_CMD: dlen = {1'b0, word[11:0]} + 13'h0001;
              OP_CHECKED_FORWARD_WRITE_TAIL_CMD,
              OP_UNCHECKED_FORWARD_WRITE_TAIL_CMD: dlen = {8'h00, word[11:7]};
              OP_CHECKED_REG_WRITE_CMD,
              OP_UNCHECKED_REG_WRITE_CMD:     dlen = {9'h000, word[3:0]} + 13'h0001;
              default:                        dlen = 13'h0000;
            endcase
            n.data_left = dlen;
            if (word[15:12] inside {[OP_CHECKED_FORWARD_WRITE_CMD : OP_UNCHECKED_FORWARD_WRITE_TAIL_CMD]}) begin
              n.job_valid = 1'b1;
              n.job_chk   = ~word[12];
              n.released  = 1'b0;
              n.all_rx    = (dlen == 13'h0000);
              n.job_words = dlen;
              n.job_xb    = word[14] ? word[6:0] : 7'h00;
              n.q_mark    = s.q_wr;
            end
            n.ph = (dlen == 13'h0000) ? P_CRC : P_DATA;
          end
          P_DATA: begin
            if (fwd_op) begin
              push = (s.q_cnt < (AW+1)'(TXQ_DEPTH));
            end
            if (rwr_op) begin
              n.regwr.stb    = 1'b1;
              n.regwr.shadow = chk;
              n.regwr.addr   = s.rd_addr;
              n.regwr.data   = word;
              n.rd_addr      = s.rd_addr + 4'h1;
            end
            n.data_left = s.data_left - 13'h0001;
            if (s.data_left == 13'h0001) begin
              n.ph     = P_CRC;
              n.all_rx = fwd_op ? 1'b1 : s.all_rx;
            end
          end
          P_CRC: begin
            if (fwd_op && chk) begin
              if (ok) begin
                n.released = 1'b1;
              end else begin
                flush       = 1'b1;
                n.job_valid = 1'b0;
                n.q_wr      = s.q_mark;
              end
            end
            if (!chk && !ok) begin
              n.crc_err = 1'b1;
            end
            n.commit   = (op == OP_CHECKED_REG_WRITE_CMD) && ok;
            n.soft_rst = (op == OP_CHECKED_SOFT_RESET_CMD) && ok && (s.cmd[11:0] == SOFT_RESET_KEY);
            if (ack_op) begin
              ret_w = status_word_in;
              rl    = cfg_in.ack_disable_bit ? 9'h000 : 9'h001;
            end else if (rd_op) begin
              ret_w = rd_word_in;
              rl    = (chk && !ok) ? 9'h000 : s.ret_len;
            end
            n.crc_tx  = s.xmodem ? CRC_INIT_XMODEM : CRC_INIT_CCITT;
            n.ret_crc = 1'b0;
            if (rl == 9'h000) begin
              n.ph = P_DONE;
            end else begin
              n.ph       = P_RET;
              n.tx_sh    = ret_w;
              n.ret_left = rl;
              n.rd_pop   = rd_op;
              n.rd_addr  = rd_op ? s.rd_addr + 4'h1 : s.rd_addr;
            end
          end
          P_RET: begin
            if (s.ret_crc) begin
              n.ph = P_DONE;
            end else if (s.ret_left > 9'h001) begin
              n.tx_sh    = rd_op ? rd_word_in : status_word_in;
              n.ret_left = s.ret_left - 9'h001;
              n.rd_pop   = rd_op;
              n.rd_addr  = s.rd_addr + 4'h1;
            end else begin
              n.tx_sh   = crc_nx;
              n.ret_crc = 1'b1;
            end
          end
          P_DONE: begin
          end
        endcase
      end
    end else if (fall && s.ph == P_RET && s.bitc != 4'h0) begin
      n.tx_sh = {s.tx_sh[14:0], 1'b1};
    end

    ////////////////////////////////////////////////////////////////////////////
    // link clock made here by division; data moves on its falling edge
    bit_tick = (s.div == DIV_LAST) && s.lclk;
    n.div    = (s.div == DIV_LAST) ? '0 : s.div + DIV_W'(1);
    if (s.div == DIV_LAST) begin
      n.lclk = ~s.lclk;
    end
    if (bit_tick) begin
      unique case (s.lst)
        L_IDLE: begin
          n.ldat = 1'b0;
          if (s.job_valid && s.released) begin
            if (s.job_words != 13'h0000) begin
              n.lst  = L_START;
              n.ldat = 1'b1;
            end else if (s.job_xb != 7'h00) begin
              n.lst   = L_XEND;
              n.lsh   = {END_BYTE, 8'h00};
              n.ldat  = END_BYTE[7];
              n.lbits = 4'h0;
            end else begin
              n.job_valid = 1'b0;
            end
          end
        end
        L_START: begin
          if (s.job_words == 13'h0000) begin
            n.lst   = L_END;
            n.lsh   = {END_BYTE, 8'h00};
            n.ldat  = END_BYTE[7];
            n.lbits = 4'h0;
          end else if (s.q_cnt != '0) begin
            pop     = 1'b1;
            n.lsh   = qword;
            n.ldat  = qword[15];
            n.lbits = 4'h0;
            n.lst   = L_DATA;
          end else begin
            n.ldat = 1'b0; // queue ran dry: line held low until the next word
          end
        end
        L_DATA: begin
          if (s.lbits == 4'hf) begin
            n.ldat      = ~s.lsh[15];
            n.job_words = s.job_words - 13'h0001;
            n.lst       = L_START;
          end else begin
            n.lsh   = {s.lsh[14:0], 1'b0};
            n.ldat  = s.lsh[14];
            n.lbits = s.lbits + 4'h1;
          end
        end
        L_END, L_XEND: begin
          if (s.lbits == 4'h7) begin
            xb_left  = (s.lst == L_XEND) ? s.job_xb - 7'h01 : s.job_xb;
            n.job_xb = xb_left;
            if (xb_left != 7'h00) begin
              n.lst   = L_XEND;
              n.lsh   = {END_BYTE, 8'h00};
              n.ldat  = END_BYTE[7];
              n.lbits = 4'h0;
            end else begin
              n.lst       = L_IDLE;
              n.ldat      = 1'b0;
              n.job_valid = 1'b0;
            end
          end else begin
            n.lsh   = {s.lsh[14:0], 1'b0};
            n.ldat  = s.lsh[14];
            n.lbits = s.lbits + 4'h1;
          end
        end
      endcase
    end

    // cut unchecked job sends only what arrived; the link may take a word this cycle
    if (cut && !s.job_chk) begin
      n.job_words = n.job_words - s.data_left;
    end

    // flush and pop never meet: a checked job drains only after release
    q_base  = flush ? s.q_cnt - {1'b0, s.q_wr - s.q_mark} : s.q_cnt;
    n.q_cnt = q_base + (AW+1)'(push) - (AW+1)'(pop);
    if (push) begin
      n.q_wr = s.q_wr + AW'(1);
    end
    if (pop) begin
      n.q_rd = s.q_rd + AW'(1);
    end
    n.sdo   = (n.ph == P_RET) ? n.tx_sh[15] : 1'b1;
    n.fault = n.crc_err & ~cfg_in.fault_mask;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  // queue storage carries no reset; only written words are ever read
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[s.q_wr] <= word;
    end
  end

  assign spi_sdo_out      = s.sdo;
  assign rd_sel_out       = s.rd_sel;
  assign rd_addr_out      = s.rd_addr;
  assign rd_pop_out       = s.rd_pop;
  assign regwr_out        = s.regwr;
  assign reg_commit_out   = s.commit;
  assign soft_reset_out   = s.soft_rst;
  assign crc_err_flag_out = s.crc_err;
  assign fault_od_out     = 1'b0;
  assign fault_oe_n_out   = ~s.fault;
  assign link_clk_out     = s.lclk;
  assign link_dat_out     = s.ldat;
  assign link_busy_out    = s.job_valid;

endmodule // sfce_engine

`default_nettype wire

// *** sim/sfce_engine_sva.sv ***
// port-level checks of the forward command engine.
// assumes a bind onto sfce_engine and a single core clock domain.
`timescale 1ns/1ps
`default_nettype none

module sfce_engine_sva
  import sfce_pkg::*;
(
  input wire logic      core_clk_in,
  input wire logic      reset_n_in,
  input wire logic      spi_cs_n_in,
  input wire sfce_cfg_s cfg_in,
  input wire logic      crc_err_clear_in,
  input wire logic      spi_sdo_out,
  input wire logic      crc_err_flag_out,
  input wire logic      fault_od_out,
  input wire logic      fault_oe_n_out,
  input wire logic      link_clk_out,
  input wire logic      link_dat_out,
  input wire logic      link_busy_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  ////////////////////////////////////////////////////////////////////////////
  sequence high_phase;
    link_clk_out [*4];
  endsequence
  sequence low_phase;
    !link_clk_out [*4];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_fault_value_low: assert property (fault_od_out == 1'b0)
    else $error("fault pin value not low");
  a_fault_follows_flag: assert property (
    fault_oe_n_out == !(crc_err_flag_out && !$past(cfg_in.fault_mask)))
    else $error("fault enable does not follow flag and mask");
  a_flag_stays_set: assert property (crc_err_flag_out && !crc_err_clear_in |=> crc_err_flag_out)
    else $error("crc flag lost without clear");
  a_sdo_idle_high: assert property (spi_cs_n_in [*8] |-> spi_sdo_out)
    else $error("sdo not high while deselected");
  a_link_clk_period: assert property ($rose(link_clk_out) |-> high_phase ##1 low_phase ##1 link_clk_out)
    else $error("link clock period wrong");
  a_dat_on_fall: assert property ($changed(link_dat_out) |-> !link_clk_out)
    else $error("link data moved off the falling edge");
  a_dat_in_job: assert property (link_dat_out |-> link_busy_out || $past(link_busy_out))
    else $error("link data high outside a job");
  a_link_idle_low: assert property (!link_busy_out && !$past(link_busy_out) |-> !link_dat_out)
    else $error("link data not idle low");
endmodule // sfce_engine_sva

`default_nettype wire

// *** sim/sfce_host_model.sv ***
// host spi controller model, mode 0, msb first.
// assumes the core clock paces it; all changes land 1 ns after an edge.
`timescale 1ns/1ps
`default_nettype none

module sfce_host_model (
  input  wire logic core_clk_in,
  input  wire logic spi_sdo_in,
  output logic      spi_sclk_out,
  output logic      spi_cs_n_out,
  output logic      spi_sdi_out
);
  initial begin
    spi_sclk_out = 1'b0;
    spi_cs_n_out = 1'b1;
    spi_sdi_out  = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  // gap longer than one word so a silent reset has settled
  task automatic sel(input logic en);
    tick(340);
    spi_cs_n_out = ~en;
    spi_sdi_out  = 1'b1;
  endtask

  // slow half period so returned bits have settled at the sampling rise
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    for (int i = 15; i >= 0; i--) begin
      spi_sdi_out = w[i]; // callers pass all ones while reading
      tick(10);
      spi_sclk_out = 1'b1;
      r[i] = spi_sdo_in;
      tick(10);
      spi_sclk_out = 1'b0;
    end
  endtask
endmodule // sfce_host_model

`default_nettype wire

// *** sim/sfce_engine_tb_top.sv ***
// self-checking bench of the forward command engine.
// assumes the host model drives the port; link bits are taken at link clock rise.
`timescale 1ns/1ps
`default_nettype none

module sfce_engine_tb_top;
  import sfce_pkg::*;
  localparam logic [15:0] STATUS = 16'h5a3c;
  logic        core_clk_in;
  logic        reset_n_in;
  logic        sclk;
  logic        cs_n;
  logic        sdi;
  logic        sdo;
  logic        clr;
  logic        flag;
  logic        fod;
  logic        foe_n;
  logic        lclk;
  logic        ldat;
  logic        busy;
  logic        capture;
  logic [15:0] stw;
  sfce_regwr_s wr;
  logic        commit;
  logic        srst;
  int          ncommit;
  int          nsrst;
  logic [20:0] wq[$];
  sfce_cfg_s   cfg;
  int          num_errors;
  int          compares;
  logic        q[$];
  logic [15:0] dd [4] = '{16'ha5c3, 16'h0f18, 16'h8001, 16'h7ffe};

  sfce_host_model sfce_host_model_i (.core_clk_in(core_clk_in), .spi_sdo_in(sdo), .spi_sclk_out(sclk),
    .spi_cs_n_out(cs_n), .spi_sdi_out(sdi));
  sfce_engine sfce_engine_i (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .spi_sclk_in(sclk),
    .spi_cs_n_in(cs_n), .spi_sdi_in(sdi), .spi_sdo_out(sdo), .cfg_in(cfg), .status_word_in(stw),
    .rd_word_in(16'h0000), .rd_sel_out(), .rd_addr_out(), .rd_pop_out(), .regwr_out(wr), .reg_commit_out(commit),
    .soft_reset_out(srst), .crc_err_clear_in(clr), .crc_err_flag_out(flag), .fault_od_out(fod),
    .fault_oe_n_out(foe_n), .link_clk_out(lclk), .link_dat_out(ldat), .link_busy_out(busy));

  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  always @(posedge lclk) if (capture) q.push_back(ldat);
  always @(posedge core_clk_in) begin
    if (wr.stb) wq.push_back({wr.shadow, wr.addr, wr.data});
    if (commit) ncommit++;
    if (srst) nsrst++;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] crc_w(input logic [15:0] c, input logic [15:0] w);
    for (int i = 15; i >= 0; i--) c = (c[15] ^ w[i]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
    return c;
  endfunction

  task automatic bad(input string m);
    num_errors++;
    $display("BAD %0t %s", $time, m);
  endtask

  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // one whole command; expected link bits built from count, words and extras
  task automatic run_fwd(input logic [15:0] cmd, input int n, input bit good, input bit fwd, input int x);
    logic [15:0] c, r0, r1, i0;
    logic        e[$];
    int          k, fl, p, m;
    i0 = cfg.crc_xmodem ? 16'h0000 : 16'hffff;
    c = crc_w(i0, cmd);
    q.delete();
    capture = 1'b1;
    sfce_host_model_i.sel(1'b1);
    sfce_host_model_i.xfer(cmd, r0);
    for (int j = 0; j < n; j++) begin
      sfce_host_model_i.xfer(dd[j], r0);
      c = crc_w(c, dd[j]);
    end
    sfce_host_model_i.xfer(good ? c : ~c, r0);
    sfce_host_model_i.xfer(16'hffff, r0); // both returned words clocked out
    sfce_host_model_i.xfer(16'hffff, r1);
    sfce_host_model_i.sel(1'b0);
    for (k = 0; k < 5000 && busy !== 1'b0; k++) @(posedge core_clk_in);
    if (k == 5000) begin
      bad("busy never dropped");
      end_sim();
    end
    sfce_host_model_i.tick(40);
    capture = 1'b0;
    if (fwd && n > 0) begin
      e.push_back(1'b1);
      for (int j = 0; j < n; j++) begin
        for (int b = 15; b >= 0; b--) e.push_back(dd[j][b]);
        e.push_back(~dd[j][0]);
      end
      repeat (8) e.push_back(1'b1);
    end
    fl = e.size();
    if (fwd) repeat (8 * x) e.push_back(1'b1);
    while (q.size() > 0 && q[0] !== 1'b1) void'(q.pop_front());
    // idle line after the last end byte carries no data
    while (q.size() > 0 && q[q.size() - 1] !== 1'b1) void'(q.pop_back());
    compares += 3;
    if (cfg.ack_disable_bit) begin
      if ({r0, r1} !== 32'hffffffff) bad("ack not suppressed");
    end else if (r0 !== stw || r1 !== crc_w(i0, stw)) bad("ack wrong");
    p = 0;
    m = 0;
    foreach (e[j]) begin
      // a dry queue idles the line low ahead of a word; seen only where that word's msb is one
      while (j > 1 && j < fl && (j - 1) % 17 == 0 && e[j] === 1'b1 && p < q.size() && q[p] === 1'b0) p++;
      if (p >= q.size() || q[p] !== e[j]) m++;
      p++;
    end
    if (p != q.size()) bad("link length wrong");
    if (m != 0) bad("link bit wrong");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_checked_ok();
    cfg.transmit_start_threshold = 10'h3ff;
    run_fwd(16'h2001, 2, 1'b1, 1'b1, 0);
    compares++;
    if (flag !== 1'b0) bad("flag set on good crc");
  endtask

  task automatic t_checked_bad();
    run_fwd(16'h2001, 2, 1'b0, 1'b0, 0);
    compares++;
    if (flag !== 1'b0) bad("flag set by checked command");
  endtask

  task automatic t_unchecked_bad();
    cfg.transmit_start_threshold = 10'h002;
    run_fwd(16'h3002, 3, 1'b0, 1'b1, 0);
    compares += 3;
    if (flag !== 1'b1 || foe_n !== 1'b0) bad("fault not raised");
    cfg.fault_mask = 1'b1;
    sfce_host_model_i.tick(3);
    if (foe_n !== 1'b1) bad("masked fault still driven");
    clr = 1'b1;
    sfce_host_model_i.tick(1);
    clr = 1'b0;
    sfce_host_model_i.tick(2);
    if (flag !== 1'b0) bad("flag not cleared");
    cfg.fault_mask = 1'b0;
  endtask

  task automatic t_tail_zero();
    cfg.crc_xmodem = 1'b1;
    run_fwd(16'h4003, 0, 1'b1, 1'b1, 3);
    cfg.crc_xmodem = 1'b0;
  endtask

  task automatic t_tail_words();
    run_fwd(16'h5101, 2, 1'b0, 1'b1, 1);
  endtask

  task automatic t_ack_off();
    cfg.ack_disable_bit = 1'b1;
    run_fwd(16'h3000, 1, 1'b1, 1'b1, 0);
    cfg.ack_disable_bit = 1'b0;
  endtask

  task automatic t_reg_write();
    stw     = 16'hc3a5;
    wq.delete();
    ncommit = 0;
    nsrst   = 0;
    run_fwd(16'ha042, 3, 1'b1, 1'b0, 0);
    run_fwd(16'he1e1, 0, 1'b1, 1'b0, 0);
    compares += 2;
    if (wq.size() != 3 || ncommit != 1 || nsrst != 1) bad("register write pulses wrong");
    foreach (wq[j]) if (wq[j] !== {1'b1, 4'(j + 1), dd[j]}) bad("register write word wrong");
  endtask

  initial begin
    reset_n_in = 1'b0;
    cfg        = '0;
    clr        = 1'b0;
    capture    = 1'b0;
    stw        = STATUS;
    num_errors = 0;
    compares   = 0;
    repeat (8) @(posedge core_clk_in);
    #1;
    reset_n_in = 1'b1;
    t_checked_ok();
    t_checked_bad();
    t_unchecked_bad();
    t_tail_zero();
    t_tail_words();
    t_ack_off();
    t_reg_write();
    end_sim();
  end
endmodule // sfce_engine_tb_top

bind sfce_engine sfce_engine_sva sfce_engine_sva_i (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
  .spi_cs_n_in(spi_cs_n_in), .cfg_in(cfg_in), .crc_err_clear_in(crc_err_clear_in), .spi_sdo_out(spi_sdo_out),
  .crc_err_flag_out(crc_err_flag_out), .fault_od_out(fault_od_out), .fault_oe_n_out(fault_oe_n_out),
  .link_clk_out(link_clk_out), .link_dat_out(link_dat_out), .link_busy_out(link_busy_out));

`default_nettype wire
